// File: fesp_pkg.sv
package fesp_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] MAIN_PROT_OFFSET = 8'hC0;
    localparam logic [7:0] SEC_PROT_OFFSET = 8'hC2;
    localparam int SEC_LOCK_BIT = 7;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_RESET = 8'hF0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int SUSPEND_MAX_US = 15;
    localparam int ABORT_MAX_US = 25;
    localparam int SUSPEND_CYCLES = (SUSPEND_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int ABORT_CYCLES = (ABORT_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int SUSPEND_DELAY_CYCLES = 16;
    localparam int ABORT_DELAY_CYCLES = 32;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [5:0] {
        FESP_READ    = 6'h01,
        FESP_PROGRAM = 6'h02,
        FESP_BULK    = 6'h04,
        FESP_SECTOR  = 6'h08,
        FESP_SUSPEND = 6'h10,
        FESP_ABORT   = 6'h20
    } fesp_state_e;

    typedef struct packed {
        logic       valid;
        logic       array_sel;
        logic [2:0] sector;
        logic [7:0] data;
    } fesp_cmd_s;

endpackage : fesp_pkg

// File: fesp_flash_ctrl.sv
`timescale 1ns/1ns
module fesp_flash_ctrl #(
    parameter int SUSPEND_DELAY = fesp_pkg::SUSPEND_DELAY_CYCLES,
    parameter int ABORT_DELAY = fesp_pkg::ABORT_DELAY_CYCLES
) (
    // Clock and reset sources
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            ext_reset_i,
    input  wire logic            watchdog_i,
    input  wire logic            low_supply_i,
    input  wire logic            debug_reset_i,
    // Processor command write
    input  wire fesp_pkg::fesp_cmd_s cmd_i,
    input  wire logic            op_program_i,
    input  wire logic            op_bulk_i,
    input  wire logic            op_sector_i,
    input  wire logic            op_done_i,
    // Processor status and register read
    input  wire logic            rd_i,
    input  wire logic            rd_array_i,
    input  wire logic [2:0]      rd_sector_i,
    input  wire logic            reg_rd_i,
    input  wire logic [7:0]      reg_addr_i,
    // Test-port configuration
    input  wire logic            tp_load_i,
    input  wire logic [7:0]      tp_main_prot_i,
    input  wire logic [3:0]      tp_sec_prot_i,
    input  wire logic            tp_lock_i,
    input  wire logic            tp_full_erase_i,
    input  wire logic            tp_access_i,
    // Outputs
    output logic [7:0]           reg_data_o,
    output logic [1:0]           busy_o,
    output logic [1:0]           read_array_o,
    output logic [1:0]           toggle_flag_o,
    output logic                 rd_valid_o,
    output logic [1:0]           start_o,
    output logic [1:0]           halt_o,
    output logic [1:0]           sector_invalid_o,
    output logic                 tp_grant_o,
    output logic                 module_reset_o
);

    // ****************************************
    // Protection and lock
    // ****************************************
    logic [7:0] main_prot;
    logic [3:0] sec_prot;
    logic lock;
    logic mod_rst;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            main_prot <= 8'h00;
            sec_prot <= 4'h0;
            lock <= 1'b0;
        end else if (tp_full_erase_i) begin
            main_prot <= 8'h00;
            sec_prot <= 4'h0;
            lock <= 1'b0;
        end else if (tp_load_i && !lock) begin
            main_prot <= tp_main_prot_i;
            sec_prot <= tp_sec_prot_i;
            lock <= tp_lock_i;
        end
    end

    // Test-port access is granted only while lock is clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tp_grant_o <= 1'b0;
        end else begin
            tp_grant_o <= tp_access_i && !lock;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_data_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                fesp_pkg::MAIN_PROT_OFFSET: reg_data_o <= main_prot;
                fesp_pkg::SEC_PROT_OFFSET: reg_data_o <= {lock, 3'b000, sec_prot};
                default: reg_data_o <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Module reset
    // ****************************************
    assign mod_rst = ext_reset_i | watchdog_i | low_supply_i | debug_reset_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            module_reset_o <= 1'b0;
        end else begin
            module_reset_o <= mod_rst;
        end
    end

    // ****************************************
    // Per-array sequencers
    // ****************************************
    logic [1:0] rd_ok;

    for (genvar a = 0; a < 2; a++) begin : g_arr
        fesp_pkg::fesp_state_e state;
        fesp_pkg::fesp_state_e next_state;
        logic [2:0] erase_sector;
        logic [15:0] cnt;
        logic sel;
        logic prot;
        logic inval;
        logic go_read;

        assign sel = cmd_i.valid && (cmd_i.array_sel == 1'(a));
        // Secondary array has only four sectors
        assign prot = (a == 0) ? main_prot[cmd_i.sector] :
                      (cmd_i.sector[2] ? 1'b1 : sec_prot[cmd_i.sector[1:0]]);
        assign go_read = (cnt == 16'h0000);

        always_comb begin
            next_state = state;
            unique case (state)
                fesp_pkg::FESP_READ: begin
                    if (sel && !prot && op_program_i) begin
                        next_state = fesp_pkg::FESP_PROGRAM;
                    end else if (sel && !prot && op_bulk_i) begin
                        next_state = fesp_pkg::FESP_BULK;
                    end else if (sel && !prot && op_sector_i) begin
                        next_state = fesp_pkg::FESP_SECTOR;
                    end
                end
                fesp_pkg::FESP_PROGRAM, fesp_pkg::FESP_BULK: begin
                    // Reset ignored here
                    if (op_done_i) begin
                        next_state = fesp_pkg::FESP_READ;
                    end
                end
                fesp_pkg::FESP_SECTOR: begin
                    if (op_done_i) begin
                        next_state = fesp_pkg::FESP_READ;
                    end else if (sel && cmd_i.data == fesp_pkg::CMD_SUSPEND) begin
                        next_state = fesp_pkg::FESP_SUSPEND;
                    end else if (sel && cmd_i.data == fesp_pkg::CMD_RESET) begin
                        next_state = fesp_pkg::FESP_ABORT;
                    end
                end
                fesp_pkg::FESP_SUSPEND: begin
                    // Everything else is discarded
                    if (sel && cmd_i.data == fesp_pkg::CMD_RESUME) begin
                        next_state = fesp_pkg::FESP_SECTOR;
                    end else if (sel && cmd_i.data == fesp_pkg::CMD_RESET) begin
                        next_state = fesp_pkg::FESP_READ;
                    end
                end
                fesp_pkg::FESP_ABORT: begin
                    if (go_read) begin
                        next_state = fesp_pkg::FESP_READ;
                    end
                end
                default: next_state = fesp_pkg::FESP_READ;
            endcase
        end

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                state <= fesp_pkg::FESP_READ;
            end else if (mod_rst && state != fesp_pkg::FESP_READ) begin
                state <= fesp_pkg::FESP_ABORT;
            end else begin
                state <= next_state;
            end
        end

        // Countdown to read-array after suspend or abort
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                cnt <= 16'h0000;
            end else if (state != fesp_pkg::FESP_ABORT &&
                         (next_state == fesp_pkg::FESP_ABORT || mod_rst)) begin
                // Module reset wins over a suspend landing in the same cycle
                cnt <= 16'(ABORT_DELAY);
            end else if (state != next_state && next_state == fesp_pkg::FESP_SUSPEND) begin
                cnt <= 16'(SUSPEND_DELAY);
            end else if (cnt != 16'h0000) begin
                cnt <= cnt - 16'h0001;
            end
        end

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                erase_sector <= 3'b000;
            end else if (state == fesp_pkg::FESP_READ && next_state == fesp_pkg::FESP_SECTOR) begin
                erase_sector <= cmd_i.sector;
            end
        end

        // Sticky invalid marker for a suspended erase abandoned by a reset command
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                inval <= 1'b0;
            end else if (state == fesp_pkg::FESP_SUSPEND && next_state == fesp_pkg::FESP_READ) begin
                inval <= 1'b1;
            end else if (state == fesp_pkg::FESP_READ && next_state == fesp_pkg::FESP_SECTOR) begin
                inval <= 1'b0;
            end
        end

        logic busy_now;
        assign busy_now = (state == fesp_pkg::FESP_PROGRAM) || (state == fesp_pkg::FESP_BULK) ||
                          (state == fesp_pkg::FESP_SECTOR) || (state == fesp_pkg::FESP_ABORT) ||
                          (state == fesp_pkg::FESP_SUSPEND && !go_read);

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                toggle_flag_o[a] <= 1'b0;
            end else if (rd_i && rd_array_i == 1'(a) && busy_now) begin
                toggle_flag_o[a] <= ~toggle_flag_o[a];
            end
        end

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                busy_o[a] <= 1'b0;
                read_array_o[a] <= 1'b1;
                start_o[a] <= 1'b0;
                halt_o[a] <= 1'b0;
                sector_invalid_o[a] <= 1'b0;
            end else begin
                busy_o[a] <= busy_now;
                read_array_o[a] <= !busy_now;
                start_o[a] <= (state != next_state) && (next_state == fesp_pkg::FESP_SECTOR);
                halt_o[a] <= (state == fesp_pkg::FESP_SUSPEND) || (state == fesp_pkg::FESP_ABORT);
                sector_invalid_o[a] <= inval;
            end
        end

        assign rd_ok[a] = !(((state == fesp_pkg::FESP_SUSPEND) || inval) &&
                            rd_sector_i == erase_sector);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_i && rd_ok[rd_array_i];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_suspend_needs_erase;
        @(posedge clk_i) disable iff (rst_i)
        (g_arr[0].state != fesp_pkg::FESP_SECTOR && !mod_rst) |=>
            g_arr[0].state != fesp_pkg::FESP_SUSPEND ||
            $past(g_arr[0].state) == fesp_pkg::FESP_SUSPEND;
    endproperty
    a_suspend_needs_erase: assert property (p_suspend_needs_erase)
        else $error("suspend outside erase");

    property p_suspend_enter;
        @(posedge clk_i) disable iff (rst_i)
        (g_arr[0].state == fesp_pkg::FESP_SECTOR && g_arr[0].sel && !op_done_i && !mod_rst &&
         cmd_i.data == fesp_pkg::CMD_SUSPEND) |=> g_arr[0].state == fesp_pkg::FESP_SUSPEND;
    endproperty
    a_suspend_enter: assert property (p_suspend_enter) else $error("suspend not taken");

    property p_suspend_settle;
        @(posedge clk_i) disable iff (rst_i)
        $rose(g_arr[0].state == fesp_pkg::FESP_SUSPEND) |-> ##[1:20] !g_arr[0].busy_now;
    endproperty
    a_suspend_settle: assert property (p_suspend_settle) else $error("suspend slow");

    property p_reset_ignored;
        @(posedge clk_i) disable iff (rst_i)
        (g_arr[1].state == fesp_pkg::FESP_PROGRAM && !op_done_i && !mod_rst) |=>
            g_arr[1].state == fesp_pkg::FESP_PROGRAM;
    endproperty
    a_reset_ignored: assert property (p_reset_ignored) else $error("program disturbed");

    property p_abort_bound;
        @(posedge clk_i) disable iff (rst_i)
        $rose(g_arr[0].state == fesp_pkg::FESP_ABORT) |->
            ##[1:40] g_arr[0].state == fesp_pkg::FESP_READ;
    endproperty
    a_abort_bound: assert property (p_abort_bound) else $error("abort too slow");

    property p_protect;
        @(posedge clk_i) disable iff (rst_i)
        (g_arr[0].state == fesp_pkg::FESP_READ && g_arr[0].prot && !mod_rst) |=>
            g_arr[0].state == fesp_pkg::FESP_READ;
    endproperty
    a_protect: assert property (p_protect) else $error("protected sector written");

    property p_sec_reg;
        @(posedge clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == fesp_pkg::SEC_PROT_OFFSET) |=>
            reg_data_o == {$past(lock), 3'b000, $past(sec_prot)};
    endproperty
    a_sec_reg: assert property (p_sec_reg) else $error("secondary register wrong");

    property p_lock_blocks;
        @(posedge clk_i) disable iff (rst_i)
        lock |=> !tp_grant_o;
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) else $error("test port not blocked");

    property p_toggle_idle;
        @(posedge clk_i) disable iff (rst_i)
        (g_arr[0].state == fesp_pkg::FESP_READ) |=> $stable(toggle_flag_o[0]);
    endproperty
    a_toggle_idle: assert property (p_toggle_idle) else $error("toggle while idle");

    c_suspend: cover property (@(posedge clk_i) g_arr[0].state == fesp_pkg::FESP_SUSPEND);
    c_resume: cover property (@(posedge clk_i)
        $past(g_arr[0].state) == fesp_pkg::FESP_SUSPEND &&
        g_arr[0].state == fesp_pkg::FESP_SECTOR);
    c_abort: cover property (@(posedge clk_i) g_arr[1].state == fesp_pkg::FESP_ABORT);

endmodule : fesp_flash_ctrl

// File: fesp_cpu_model.sv
`timescale 1ns/1ns
module fesp_cpu_model (
    // Clock
    input  wire logic clk_i,
    // Command write and reads
    output fesp_pkg::fesp_cmd_s cmd_o,
    output logic [2:0] op_o,
    output logic rd_o,
    output logic rd_array_o,
    output logic [2:0] rd_sector_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o
);
    initial begin
        cmd_o = '0;
        op_o = 3'h0;
        rd_o = 1'b0;
        rd_array_o = 1'b0;
        rd_sector_o = 3'h0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
    end

    // Released lines other than op_o show the inverse so stale values never look valid
    task automatic write_cmd(input logic a, input logic [2:0] s, input logic [7:0] d,
                             input logic [2:0] op);
        cmd_o = '{1'b1, a, s, d};
        op_o = op;
        @(posedge clk_i);
        #1;
        cmd_o = '{1'b0, ~a, ~s, ~d};
        op_o = 3'h0;
    endtask : write_cmd

    task automatic read_flash(input logic a, input logic [2:0] s);
        rd_o = 1'b1;
        rd_array_o = a;
        rd_sector_o = s;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        rd_array_o = ~a;
        rd_sector_o = ~s;
    endtask : read_flash

    task automatic read_reg(input logic [7:0] addr);
        reg_rd_o = 1'b1;
        reg_addr_o = addr;
        @(posedge clk_i);
        #1;
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
    endtask : read_reg
endmodule : fesp_cpu_model

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top;
    // ****************************************
    // Bench signals
    // ****************************************
    localparam int SD = 2;
    localparam int AD = 4;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] src = 4'h0;
    logic tp_load = 1'b0;
    logic tp_lock = 1'b0;
    logic tp_full = 1'b0;
    logic tp_access = 1'b0;
    logic op_done = 1'b0;
    logic [7:0] tp_main = 8'h00;
    logic [3:0] tp_sec = 4'h0;
    fesp_pkg::fesp_cmd_s cmd;
    logic [2:0] op, rd_sec;
    logic rd, rd_arr, reg_rd, rd_valid, grant, mod_rst;
    logic rd_seen = 1'b0;
    logic reg_seen = 1'b0;
    logic [7:0] reg_addr, reg_data, mp, t;
    logic [1:0] busy, ra, tgl, start, halt, inval, e;
    logic [1:0] rdq[$];
    logic [7:0] regq[$];
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    integer seed = 80;

    initial forever #5 clk_i = ~clk_i;

    fesp_cpu_model cpu_u (.clk_i(clk_i), .cmd_o(cmd), .op_o(op), .rd_o(rd),
        .rd_array_o(rd_arr), .rd_sector_o(rd_sec), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr));

    fesp_flash_ctrl #(.SUSPEND_DELAY(SD), .ABORT_DELAY(AD)) dut_u (.clk_i(clk_i),
        .rst_i(rst_i), .ext_reset_i(src[0]), .watchdog_i(src[1]), .low_supply_i(src[2]),
        .debug_reset_i(src[3]), .cmd_i(cmd), .op_program_i(op[2]), .op_bulk_i(op[1]),
        .op_sector_i(op[0]), .op_done_i(op_done), .rd_i(rd), .rd_array_i(rd_arr),
        .rd_sector_i(rd_sec), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
        .tp_load_i(tp_load), .tp_main_prot_i(tp_main), .tp_sec_prot_i(tp_sec),
        .tp_lock_i(tp_lock), .tp_full_erase_i(tp_full), .tp_access_i(tp_access),
        .reg_data_o(reg_data), .busy_o(busy), .read_array_o(ra), .toggle_flag_o(tgl),
        .rd_valid_o(rd_valid), .start_o(start), .halt_o(halt), .sector_invalid_o(inval),
        .tp_grant_o(grant), .module_reset_o(mod_rst));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_i);
            #1;
        end
    endtask : tick

    task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : cmp8

    task automatic rdf(input logic a, input logic [2:0] s, input logic [1:0] exp);
        rdq.push_back(exp);
        cpu_u.read_flash(a, s);
        // Idle edge so a following read never re-raises the strobe in the same step
        tick(1);
    endtask : rdf

    task automatic rr(input logic [7:0] addr, input logic [7:0] exp);
        regq.push_back(exp);
        cpu_u.read_reg(addr);
        tick(1);
    endtask : rr

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        tick(1);
        sig = 1'b0;
        tick(2);
    endtask : pulse

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // Result watcher and timeout
    // ****************************************
    always @(posedge clk_i) begin
        rd_seen <= rd;
        reg_seen <= reg_rd;
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // Entries carry a care bit; status reads during an erase are not data
    always @(negedge clk_i) begin
        if (rd_seen && rdq.size() > 0) begin
            e = rdq.pop_front();
            if (e[1])
                cmp8({7'h0, e[0]}, {7'h0, rd_valid});
        end
        if (reg_seen && regq.size() > 0)
            cmp8(regq.pop_front(), reg_data);
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        tick(20);
        rst_i = 1'b0;
        tick(1);
        cmp8(8'h03, {6'h0, ra});
        mp = (8'($random(seed)) & 8'h7C) | 8'h80;
        tp_main = mp;
        tp_sec = 4'($random(seed)) & 4'hC;
        tp_access = 1'b1;
        pulse(tp_load);
        cmp8(8'h01, {7'h0, grant});
        rr(8'hC0, mp);
        rr(8'hC2, {4'h0, tp_sec});
        rr(8'hC1, 8'h00);
        $display("test protection registers ended");
        cpu_u.write_cmd(1'b0, 3'd1, fesp_pkg::CMD_SUSPEND, 3'h0);
        tick(3);
        cmp8(8'h00, {4'h0, halt, busy});
        cpu_u.write_cmd(1'b0, 3'd1, 8'h00, 3'h1);
        // Start pulse leads busy by one cycle
        cmp8(8'h04, {2'h0, halt, start, busy});
        tick(2);
        cmp8(8'h01, {2'h0, halt, start, busy});
        t = {6'h0, tgl};
        rdf(1'b0, 3'd1, 2'b00);
        tick(1);
        cmp8(t ^ 8'h01, {6'h0, tgl});
        cpu_u.write_cmd(1'b0, 3'd3, fesp_pkg::CMD_SUSPEND, 3'h0);
        tick(SD + 4);
        cmp8(8'h13, {2'h0, halt, busy, ra});
        t = {6'h0, tgl};
        rdf(1'b0, 3'd2, 2'b11);
        rdf(1'b0, 3'd1, 2'b10);
        tick(1);
        cmp8(t, {6'h0, tgl});
        cpu_u.write_cmd(1'b0, 3'd2, 8'h00, 3'h4);
        tick(3);
        cmp8(8'h13, {2'h0, halt, busy, ra});
        cpu_u.write_cmd(1'b0, 3'd1, fesp_pkg::CMD_RESUME, 3'h0);
        cmp8(8'h14, {2'h0, halt, start, busy});
        tick(2);
        cmp8(8'h01, {2'h0, halt, start, busy});
        cpu_u.write_cmd(1'b0, 3'd1, fesp_pkg::CMD_RESET, 3'h0);
        tick(AD + 4);
        cmp8(8'h03, {2'h0, halt, busy, ra});
        $display("test suspend resume abort ended");
        cpu_u.write_cmd(1'b0, 3'd0, 8'h00, 3'h1);
        tick(2);
        cpu_u.write_cmd(1'b0, 3'd0, fesp_pkg::CMD_SUSPEND, 3'h0);
        tick(SD + 4);
        cpu_u.write_cmd(1'b0, 3'd0, fesp_pkg::CMD_RESET, 3'h0);
        tick(2);
        cmp8(8'h13, {2'h0, inval, halt, ra});
        for (int k = 0; k < 2; k++) begin
            cpu_u.write_cmd(1'b1, 3'd0, 8'h00, (k == 0) ? 3'h4 : 3'h2);
            tick(2);
            cpu_u.write_cmd(1'b1, 3'd0, fesp_pkg::CMD_RESET, 3'h0);
            tick(AD + 4);
            cmp8(8'h02, {6'h0, busy});
            pulse(op_done);
            cmp8(8'h00, {6'h0, busy});
        end
        cpu_u.write_cmd(1'b0, 3'd7, 8'h00, 3'h1);
        tick(3);
        cmp8(8'h00, {6'h0, busy});
        $display("test reset commands ended");
        for (int i = 0; i < 4; i++) begin
            cpu_u.write_cmd(1'b0, 3'd0, 8'h00, 3'h1);
            tick(1);
            cpu_u.write_cmd(1'b1, 3'd1, 8'h00, 3'h4);
            tick(2);
            cmp8(8'h03, {6'h0, busy});
            src = 4'h1 << i;
            tick(1);
            cmp8(8'h01, {7'h0, mod_rst});
            src = 4'h0;
            tick(AD + 4);
            cmp8(8'h03, {4'h0, busy, ra});
        end
        $display("test module reset ended");
        tp_lock = 1'b1;
        pulse(tp_load);
        cmp8(8'h00, {7'h0, grant});
        rr(8'hC2, {4'h8, tp_sec});
        tp_main = 8'h00;
        pulse(tp_load);
        rr(8'hC0, mp);
        rdf(1'b0, 3'd2, 2'b11);
        pulse(tp_full);
        cmp8(8'h01, {7'h0, grant});
        rr(8'hC0, 8'h00);
        rr(8'hC2, 8'h00);
        tick(2);
        $display("test security lock ended");
        tally_and_finish();
    end
endmodule : tb_top
